/* rtl/mim_pkg.sv */
// Package: register offsets, field positions, reset values and widths of the monitor interrupt mask logic
package mim_pkg;
  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [7:0] OFF_CONFIG      = 8'h00;
  localparam logic [7:0] OFF_STATUS_ONE  = 8'h01;
  localparam logic [7:0] OFF_STATUS_TWO  = 8'h02;
  localparam logic [7:0] OFF_MASK_FIRST  = 8'h03;
  localparam logic [7:0] OFF_MASK_SECOND = 8'h04;
  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [7:0] RST_MASK_FIRST  = 8'h00;
  localparam logic [7:0] RST_MASK_SECOND = 8'h00;
  localparam logic [7:0] RST_STATUS      = 8'h00;
  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int CFG_INT_ENABLE_BIT = 1;
  localparam int S2_HOT_BIT         = 0;
  localparam int S2_BOARD_BIT       = 1;
  localparam int S2_TACH_ONE_BIT    = 2;
  localparam int S2_TACH_TWO_BIT    = 3;
  localparam int S2_CHASSIS_BIT     = 4;
  localparam int S2_OVERTEMP_BIT    = 5;
  localparam int M2_HOT_MODE_BIT    = 6;
  localparam int M2_OT_MODE_BIT     = 7;
  localparam int S2_USED_BITS       = 6;
  localparam int VOLT_CHANNELS      = 7;
endpackage

/* rtl/mim_temp_flag.sv */
// Module: one temperature status flag with default and one-time interrupt modes
`timescale 1ns/1ps
module mim_temp_flag (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic one_time,
  input  wire logic conv_done,
  input  wire logic above_limit,
  input  wire logic below_hyst,
  input  wire logic status_read,
  output logic      flag
);
  // ******************************************************
  // Alarm state
  // ******************************************************
  logic hot;
  logic set_ev;

  // Hot latches on crossing the limit and releases below hysteresis
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hot <= 1'b0;
    end else if (conv_done && above_limit) begin
      hot <= 1'b1;
    end else if (conv_done && below_hyst) begin
      hot <= 1'b0;
    end
  end

  // Default mode repeats each conversion while hot; one-time mode fires only on a crossing
  always_comb begin
    if (one_time) begin
      set_ev = conv_done && ((!hot && above_limit) || (hot && below_hyst && !above_limit));
    end else begin
      set_ev = conv_done && (above_limit || (hot && !below_hyst));
    end
  end

  // Set wins over the read clear so a coincident event is kept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set_ev) begin
      flag <= 1'b1;
    end else if (status_read) begin
      flag <= 1'b0;
    end
  end
endmodule

/* rtl/mim_top.sv */
// Module: interrupt status, mask registers and interrupt output of the hardware monitor
`timescale 1ns/1ps
module mim_top (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       conv_done,
  input  wire logic [6:0] volt_out_of_range,
  input  wire logic       ext_int_in_n,
  input  wire logic       board_temp_alert_input_n,
  input  wire logic       tach_one_alarm,
  input  wire logic       tach_two_alarm,
  input  wire logic       chassis_intrusion_input,
  input  wire logic       hot_above_limit,
  input  wire logic       hot_below_hyst,
  input  wire logic       ot_above_limit,
  input  wire logic       ot_below_hyst,
  output logic            int_out,
  output logic            int_oe_n
);
  // ******************************************************
  // Registers and synchronisers
  // ******************************************************
  logic [7:0] interrupt_mask_first;
  logic [7:0] interrupt_mask_second;
  logic [7:0] config_reg;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic       read_one;
  logic       read_two;
  logic       hot_flag;
  logic       ot_flag;
  logic       int_any;
  logic       ext_flag;

  // ******************************************************
  // Elaboration checks and decode helpers
  // ******************************************************
  // Seven voltage flags plus the pin flag must fill the first status byte exactly
  if (mim_pkg::VOLT_CHANNELS != 7) begin : g_bad_volt_count
    $error("voltage channel count does not match the first status layout");
  end

  // Six sources share the second status byte; the top two mask bits are mode selects
  if (mim_pkg::S2_USED_BITS != 6) begin : g_bad_s2_count
    $error("second status source count does not match the mask layout");
  end

  // One compare shared by every write path and both status read-clear strobes; the read mux decodes reg_addr by case
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // Asynchronous pins: two flops before any logic looks at them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {chassis_intrusion_input, !board_temp_alert_input_n, !ext_int_in_n};
      pin_sync <= pin_meta;
    end
  end

  assign read_one = reg_rd && addr_is(reg_addr, mim_pkg::OFF_STATUS_ONE);
  assign read_two = reg_rd && addr_is(reg_addr, mim_pkg::OFF_STATUS_TWO);

  // ******************************************************
  // Register writes
  // ******************************************************
  // Masks come up clear so nothing is hidden after power-up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interrupt_mask_first  <= mim_pkg::RST_MASK_FIRST;
      interrupt_mask_second <= mim_pkg::RST_MASK_SECOND;
    end else if (reg_wr && addr_is(reg_addr, mim_pkg::OFF_MASK_FIRST)) begin
      interrupt_mask_first <= reg_wdata;
    end else if (reg_wr && addr_is(reg_addr, mim_pkg::OFF_MASK_SECOND)) begin
      interrupt_mask_second <= reg_wdata;
    end
  end

  // Only the interrupt enable field is kept; other config fields belong elsewhere
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      config_reg <= mim_pkg::RST_STATUS;
    end else if (reg_wr && addr_is(reg_addr, mim_pkg::OFF_CONFIG)) begin
      config_reg <= {6'h00, reg_wdata[mim_pkg::CFG_INT_ENABLE_BIT], 1'b0};
    end
  end

  // ******************************************************
  // Status flags
  // ******************************************************
  // Voltage flags: one sticky bit per channel, recorded whatever the mask says
  for (genvar ch = 0; ch < mim_pkg::VOLT_CHANNELS; ch++) begin : g_volt_flag
    logic flag_q;
    // A set beats a coincident read clear so no conversion result is lost
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        flag_q <= mim_pkg::RST_STATUS[ch];
      end else if (conv_done && volt_out_of_range[ch]) begin
        flag_q <= 1'b1;
      end else if (read_one) begin
        flag_q <= 1'b0;
      end
    end
    assign status_one[ch] = flag_q;
  end

  // External interrupt flag re-sets while the synchronised pin stays low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_flag <= mim_pkg::RST_STATUS[7];
    end else if (pin_sync[0]) begin
      ext_flag <= 1'b1;
    end else if (read_one) begin
      ext_flag <= 1'b0;
    end
  end
  assign status_one[7] = ext_flag;

  // Board, tach and chassis flags are sticky until read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_two <= mim_pkg::RST_STATUS;
    end else begin
      status_two[mim_pkg::S2_BOARD_BIT] <= pin_sync[1] | (status_two[mim_pkg::S2_BOARD_BIT] & !read_two);
      status_two[mim_pkg::S2_TACH_ONE_BIT] <= tach_one_alarm | (status_two[mim_pkg::S2_TACH_ONE_BIT] & !read_two);
      status_two[mim_pkg::S2_TACH_TWO_BIT] <= tach_two_alarm | (status_two[mim_pkg::S2_TACH_TWO_BIT] & !read_two);
      status_two[mim_pkg::S2_CHASSIS_BIT] <= pin_sync[2] | (status_two[mim_pkg::S2_CHASSIS_BIT] & !read_two);
      // Hot and overtemperature flags live in their own modules; these places stay zero
      status_two[mim_pkg::S2_HOT_BIT]      <= 1'b0;
      status_two[mim_pkg::S2_OVERTEMP_BIT] <= 1'b0;
      status_two[7:6]                      <= 2'h0;
    end
  end

  // Hot temperature flag, mode from second mask bit 6
  mim_temp_flag u_hot (
    .mclk        (mclk),
    .rst         (rst),
    .one_time    (interrupt_mask_second[mim_pkg::M2_HOT_MODE_BIT]),
    .conv_done   (conv_done),
    .above_limit (hot_above_limit),
    .below_hyst  (hot_below_hyst),
    .status_read (read_two),
    .flag        (hot_flag)
  );

  // Overtemperature flag, mode from second mask bit 7
  mim_temp_flag u_ot (
    .mclk        (mclk),
    .rst         (rst),
    .one_time    (interrupt_mask_second[mim_pkg::M2_OT_MODE_BIT]),
    .conv_done   (conv_done),
    .above_limit (ot_above_limit),
    .below_hyst  (ot_below_hyst),
    .status_read (read_two),
    .flag        (ot_flag)
  );

  // ******************************************************
  // Interrupt output
  // ******************************************************
  // Masked OR across both status registers
  always_comb begin
    int_any = |(status_one & ~interrupt_mask_first);
    int_any = int_any | (hot_flag & !interrupt_mask_second[mim_pkg::S2_HOT_BIT]);
    int_any = int_any | (ot_flag & !interrupt_mask_second[mim_pkg::S2_OVERTEMP_BIT]);
    int_any = int_any | |(status_two[4:1] & ~interrupt_mask_second[4:1]);
  end

  // Registered so the pin never glitches during a register access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_out  <= 1'b0;
      int_oe_n <= 1'b1;
    end else begin
      int_out  <= int_any & config_reg[mim_pkg::CFG_INT_ENABLE_BIT];
      int_oe_n <= !config_reg[mim_pkg::CFG_INT_ENABLE_BIT];
    end
  end

  // ******************************************************
  // Read data
  // ******************************************************
  // Unmapped offsets read zero
  // Status reads show the live flags; the clear lands on the same edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        mim_pkg::OFF_CONFIG:      reg_rdata <= config_reg;
        mim_pkg::OFF_STATUS_ONE:  reg_rdata <= status_one;
        mim_pkg::OFF_STATUS_TWO:  reg_rdata <= {2'h0, ot_flag, status_two[4:1], hot_flag};
        mim_pkg::OFF_MASK_FIRST:  reg_rdata <= interrupt_mask_first;
        mim_pkg::OFF_MASK_SECOND: reg_rdata <= interrupt_mask_second;
        default:                  reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

/* verif/mim_host.sv */
// Host model: register reads and writes on the monitor's strobe bus
`timescale 1ns/1ps
module mim_host (
  input  wire logic [7:0] reg_rdata,
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // ******************************************************
  // Bus tasks
  // ******************************************************
  // Strobes last one cycle and change just after the edge
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d; // Stale data must not look valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    d = reg_rdata; // Answer registered at the taking edge
  endtask
endmodule

/* verif/mim_top_assertions.sv */
// Checker: port assertions of the monitor interrupt mask logic
`timescale 1ns/1ps
module mim_top_assertions (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       conv_done,
  input wire logic [6:0] volt_out_of_range,
  input wire logic       hot_above_limit,
  input wire logic       ot_above_limit,
  input wire logic       int_out,
  input wire logic       int_oe_n
);
  // ******************************************************
  // Shadow registers and properties
  // ******************************************************
  logic [7:0] m1;
  logic [7:0] m2;
  logic       cen;
  // Mirror of host writes, since only ports are visible here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      m1 <= 8'h00;
      m2 <= 8'h00;
      cen <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h03) m1 <= reg_wdata;
      if (reg_addr == 8'h04) m2 <= reg_wdata;
      if (reg_addr == 8'h00) cen <= reg_wdata[1];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_excl; int_oe_n |-> !int_out; endproperty
  property p_oe_off; !cen [*2] |=> int_oe_n; endproperty
  property p_oe_on; cen [*2] |=> !int_oe_n; endproperty
  property p_mask; (m1 == 8'hFF && m2[5:0] == 6'h3F) [*2] |=> !int_out; endproperty
  property p_rb; reg_rd && !reg_wr && reg_addr == 8'h03 |=> reg_rdata == m1; endproperty
  property p_volt; conv_done && !reg_wr && cen && (volt_out_of_range & ~m1[6:0]) != 7'h00 |-> ##2 int_out; endproperty
  property p_hot; conv_done && !reg_wr && cen && hot_above_limit && !m2[6] && !m2[0] |-> ##2 int_out; endproperty
  property p_ot; conv_done && !reg_wr && cen && ot_above_limit && !m2[7] && !m2[5] |-> ##2 int_out; endproperty
  a_excl: assert property (p_excl) else $error("int_out high while pin released");
  a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");
  a_oe_on: assert property (p_oe_on) else $error("pin released while enabled");
  a_mask: assert property (p_mask) else $error("interrupt despite full mask");
  a_rb: assert property (p_rb) else $error("first mask readback wrong");
  a_volt: assert property (p_volt) else $error("voltage flag gave no interrupt");
  a_hot: assert property (p_hot) else $error("hot default gave no interrupt");
  a_ot: assert property (p_ot) else $error("overtemp default gave no interrupt");
  c_hot: cover property (conv_done && hot_above_limit);
  c_rd: cover property (reg_rd && reg_addr == 8'h02);
  c_mask: cover property (m1 == 8'hFF);
endmodule
bind mim_top mim_top_assertions mim_top_assertions_i (.*);

/* verif/mim_top_tb_top.sv */
// Testbench: register and status scenarios for the monitor interrupt mask logic
`timescale 1ns/1ps
module mim_top_tb_top;
  // ******************************************************
  // Signals, tasks and scenarios
  // ******************************************************
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       reg_wr, reg_rd, int_out, int_oe_n;
  logic       conv_done = 1'b0;
  logic [6:0] volt_out_of_range = 7'h00;
  logic       ext_int_in_n = 1'b1, board_temp_alert_input_n = 1'b1, chassis_intrusion_input = 1'b0;
  logic       tach_one_alarm = 1'b0, tach_two_alarm = 1'b0;
  logic       hot_above_limit = 1'b0, hot_below_hyst = 1'b0, ot_above_limit = 1'b0, ot_below_hyst = 1'b0;
  logic [1:0] st;
  int         err_count = 0;
  int         checked = 0;
  always #2 mclk = ~mclk;
  mim_top mim_top_i (.*);
  mim_host mim_host_i (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Ends just after an edge so outputs have settled
  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Comparator levels are inverted after the pulse: only conv_done may sample them
  task automatic conv(input logic [6:0] v, input logic [3:0] t);
    @(posedge mclk);
    #1 volt_out_of_range = v;
    {ot_above_limit, ot_below_hyst, hot_above_limit, hot_below_hyst} = t;
    conv_done = 1'b1;
    @(posedge mclk);
    #1 conv_done = 1'b0;
    volt_out_of_range = ~v;
    {ot_above_limit, ot_below_hyst, hot_above_limit, hot_below_hyst} = ~t;
  endtask
  task automatic src(input int i, input logic on);
    case (i)
      0: conv(7'h00, on ? 4'b0010 : 4'b0001);
      1: board_temp_alert_input_n = !on;
      2: tach_one_alarm = on;
      3: tach_two_alarm = on;
      4: chassis_intrusion_input = on;
      default: conv(7'h00, on ? 4'b1000 : 4'b0100);
    endcase
  endtask
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    mim_host_i.rd(8'h03, d);
    chk(d, 8'h00);
    mim_host_i.rd(8'h04, d);
    chk(d, 8'h00);
    conv(7'h01, 4'h0);
    wait_c(3);
    chk({6'h00, int_oe_n, int_out}, 8'h02);
    mim_host_i.wr(8'h00, 8'hFF);
    wait_c(2);
    chk({6'h00, int_oe_n, int_out}, 8'h01);
    mim_host_i.rd(8'h00, d);
    chk(d, 8'h02);
    mim_host_i.rd(8'h01, d);
    chk(d, 8'h01);
    mim_host_i.rd(8'h01, d);
    wait_c(2);
    chk({d[6:0], int_out}, 8'h00);
    // Full mask: flags still recorded but silent
    mim_host_i.wr(8'h03, 8'hFF);
    mim_host_i.wr(8'h04, 8'h3F);
    ext_int_in_n = 1'b0;
    conv(7'h7F, 4'h0);
    wait_c(4);
    ext_int_in_n = 1'b1;
    wait_c(4);
    chk({7'h00, int_out}, 8'h00);
    mim_host_i.rd(8'h01, d);
    chk(d, 8'hFF);
    mim_host_i.wr(8'h03, 8'h00);
    // Unmasked voltage channel drives the pin two edges after its conversion
    conv(7'h40, 4'h0);
    wait_c(2);
    chk({7'h00, int_out}, 8'h01);
    mim_host_i.rd(8'h01, d);
    chk(d, 8'h40);
    // One second-mask bit open at a time
    for (int i = 0; i < 6; i++) begin
      mim_host_i.wr(8'h04, 8'h3F ^ (8'h01 << i));
      src(i, 1'b1);
      wait_c(4);
      chk({7'h00, int_out}, 8'h01);
      src(i, 1'b0);
      wait_c(4);
      mim_host_i.rd(8'h02, d);
      chk(d, 8'h01 << i);
      mim_host_i.rd(8'h02, d);
      chk(d, 8'h00);
    end
    // Steps: rise above, stay hot, fall below, stay cool; k[1] overtemp, k[0] one-time
    for (int k = 0; k < 4; k++) begin
      mim_host_i.wr(8'h04, k[0] ? (k[1] ? 8'h80 : 8'h40) : 8'h00);
      for (int s = 0; s < 4; s++) begin
        st = (s == 0) ? 2'b10 : (s == 2) ? 2'b01 : 2'b00;
        conv(7'h00, k[1] ? {st, 2'b00} : {2'b00, st});
        mim_host_i.rd(8'h02, d);
        chk(d, (s == 0 || (s == 1 && !k[0]) || (s == 2 && k[0])) ? (k[1] ? 8'h20 : 8'h01) : 8'h00);
      end
    end
    // Mid-run reset: masks and enable return to their power-up values
    mim_host_i.wr(8'h03, 8'h5A);
    @(posedge mclk);
    #1 rst = 1'b1;
    wait_c(2);
    rst = 1'b0;
    mim_host_i.rd(8'h03, d);
    chk(d, 8'h00);
    mim_host_i.rd(8'h04, d);
    chk(d, 8'h00);
    chk({6'h00, int_oe_n, int_out}, 8'h02);
    stop_test;
  end
endmodule
